// ### include/vic_pkg.sv
// vic_pkg: register offsets, field positions, reset values and mode codes
// shared by the concentrator top, the processor model and the bench.
// assumes a plain one-cycle register port with word addressing by byte offset.
package vic_pkg;
    localparam int unsigned NUM_SOURCES = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_PENDING = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_ACK = 8'h0c;
    localparam logic [7:0] OFF_VECTOR = 8'h10;
    localparam logic [7:0] OFF_GLOBAL = 8'h14;
    localparam logic [7:0] OFF_FAST = 8'h18;
    localparam logic [7:0] OFF_LEVEL = 8'h1c;
    localparam logic [7:0] OFF_SENSE = 8'h20;
    localparam logic [7:0] OFF_POLARITY = 8'h24;
    localparam logic [7:0] OFF_OUTMODE = 8'h28;
    localparam logic [7:0] OFF_VECBASE = 8'h2c;
    // global enable fields
    localparam int unsigned GBL_MASTER_BIT = 0;
    localparam int unsigned GBL_HWEN_BIT = 1;
    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [5:0] RST_LEVEL = 6'h20;
    localparam logic [5:0] NO_VECTOR = 6'h3f;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
    // processor acknowledge codes
    typedef enum logic [1:0]
    {
        VIC_ACK_NONE = 2'b00,
        VIC_ACK_ENTER = 2'b01,
        VIC_ACK_RETURN = 2'b10,
        VIC_ACK_REENABLE = 2'b11
    } vic_ack_t;
    // fast handshake state
    typedef enum logic [1:0]
    {
        VIC_FS_IDLE = 2'b00,
        VIC_FS_WAIT = 2'b01,
        VIC_FS_SERVE = 2'b10
    } vic_fast_t;
endpackage

// ### rtl/vic_capture.sv
// vic_capture: one source's detector and pending flag.
// assumes the source input is already synchronised to clock.
module vic_capture
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic src,
    input wire logic edge_mode,
    input wire logic active_high,
    input wire logic sw_set,
    input wire logic clr,
    output logic pending
);
    logic src_prev_q;
    logic hit;
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            src_prev_q <= 1'b0;
        else
            src_prev_q <= src;
    end
    // chosen edge or level; capture ignores the enable
    always_comb
    begin
        if (edge_mode)
            hit = active_high ? (src & ~src_prev_q) : (~src & src_prev_q);
        else
            hit = active_high ? src : ~src;
    end
    // set wins over clear; already pending ignores new events
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            pending <= 1'b0;
        else if (hit | sw_set)
            pending <= 1'b1;
        else if (clr)
            pending <= 1'b0;
    end
endmodule

// ### rtl/vic_top.sv
// vic_top: concentrates source inputs into one processor request.
// assumes one clock, synchronous active-high reset, a one-cycle register port.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
module vic_top
#(
    parameter int unsigned NSRC = 32,
    parameter int unsigned NSW = 0,
    parameter bit CASCADE_EN = 1'b0
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [NSRC-1:0] src_in,
    input wire logic cascade_in,
    input wire logic [1:0] processor_ack,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    output logic [31:0] vector_addr
);
    ////////////////////////////////////////////////////////////////////////
    logic [NSRC-1:0] sync1_q, sync2_q, sync3_q, src_clean_q;
    logic [NSRC-1:0] enable_q, fast_q, sense_q, polarity_q, pend, sw_set, clr;
    logic [1:0] global_q;
    logic [5:0] level_q, vec_q;
    logic outmode_q;
    logic [31:0] vecbase_q;
    logic [NSRC-1:0] armed, fast_ack_q;
    logic [5:0] win;
    logic any_req;
    logic req_prev_q;
    logic cascade_s1_q, cascade_s2_q, cascade_s3_q, cascade_q;
    vic_pkg::vic_fast_t fs_q;
    logic [5:0] fs_src_q;

    // three stages; change counts only once stage two and three agree
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            src_clean_q <= '0;
            cascade_s1_q <= 1'b0;
            cascade_s2_q <= 1'b0;
            cascade_s3_q <= 1'b0;
            cascade_q <= 1'b0;
        end
        else
        begin
            sync1_q <= src_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            src_clean_q <= (sync2_q & sync3_q) | (src_clean_q & (sync2_q | sync3_q));
            cascade_s1_q <= cascade_in;
            cascade_s2_q <= cascade_s1_q;
            cascade_s3_q <= cascade_s2_q;
            if (cascade_s2_q == cascade_s3_q)
                cascade_q <= cascade_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture cells, one per source
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++)
        begin : g_src
            logic src_eff;
            // the top source slot doubles as the cascade input when chained
            assign src_eff = (CASCADE_EN && gi == NSRC - 1) ? cascade_q : src_clean_q[gi];
            // software interrupts occupy the top NSW slots, set by status writes
            assign sw_set[gi] = (gi >= NSRC - NSW) && reg_wr && reg_addr == vic_pkg::OFF_STATUS
                && reg_wdata[gi];
            // ack write; fast sources wait for the processor handshake
            assign clr[gi] = (reg_wr && reg_addr == vic_pkg::OFF_ACK && reg_wdata[gi] && !fast_q[gi])
                || fast_ack_q[gi];
            vic_capture u_cap
            (
                .clock(clock),
                .sys_rst(sys_rst),
                .src((gi >= NSRC - NSW) ? 1'b0 : src_eff),
                .edge_mode(sense_q[gi]),
                .active_high(polarity_q[gi]),
                .sw_set(sw_set[gi]),
                .clr(clr[gi]),
                .pending(pend[gi])
            );
            // only sources with an index strictly below the current level may request
            assign armed[gi] = pend[gi] && enable_q[gi] && (6'(gi) < level_q);
        end
    endgenerate

    // lowest index wins
    always_comb
    begin
        win = vic_pkg::NO_VECTOR;
        for (int i = NSRC - 1; i >= 0; i--)
            if (armed[i])
                win = 6'(i);
    end
    assign any_req = global_q[vic_pkg::GBL_MASTER_BIT] && global_q[vic_pkg::GBL_HWEN_BIT] && (|armed);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            enable_q <= '0;
            fast_q <= '0;
            sense_q <= '0;
            polarity_q <= '1;
            global_q <= 2'b00;
            level_q <= vic_pkg::RST_LEVEL;
            outmode_q <= 1'b0;
            vecbase_q <= vic_pkg::RST_ZERO;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                vic_pkg::OFF_ENABLE: enable_q <= reg_wdata[NSRC-1:0];
                vic_pkg::OFF_FAST: fast_q <= reg_wdata[NSRC-1:0];
                vic_pkg::OFF_SENSE: sense_q <= reg_wdata[NSRC-1:0];
                vic_pkg::OFF_POLARITY: polarity_q <= reg_wdata[NSRC-1:0];
                // hw enable bit is write-once until reset, so a stray write cannot detach hardware
                vic_pkg::OFF_GLOBAL: global_q <= {global_q[1] | reg_wdata[1], reg_wdata[0]};
                vic_pkg::OFF_LEVEL: level_q <= reg_wdata[5:0];
                vic_pkg::OFF_OUTMODE: outmode_q <= reg_wdata[0];
                vic_pkg::OFF_VECBASE: vecbase_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock)
    begin
        if (sys_rst || !reg_rd)
            reg_rdata <= vic_pkg::RD_UNMAPPED;
        else
        begin
            case (reg_addr)
                vic_pkg::OFF_STATUS: reg_rdata <= 32'(pend);
                vic_pkg::OFF_PENDING: reg_rdata <= 32'(pend & enable_q);
                vic_pkg::OFF_ENABLE: reg_rdata <= 32'(enable_q);
                vic_pkg::OFF_ACK: reg_rdata <= vic_pkg::RST_ZERO;
                vic_pkg::OFF_VECTOR: reg_rdata <= 32'(vec_q);
                vic_pkg::OFF_GLOBAL: reg_rdata <= 32'(global_q);
                vic_pkg::OFF_FAST: reg_rdata <= 32'(fast_q);
                vic_pkg::OFF_LEVEL: reg_rdata <= 32'(level_q);
                vic_pkg::OFF_SENSE: reg_rdata <= 32'(sense_q);
                vic_pkg::OFF_POLARITY: reg_rdata <= 32'(polarity_q);
                vic_pkg::OFF_OUTMODE: reg_rdata <= 32'(outmode_q);
                vic_pkg::OFF_VECBASE: reg_rdata <= vecbase_q;
                default: reg_rdata <= vic_pkg::RD_UNMAPPED;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vector register and address output track the winner
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            vec_q <= vic_pkg::NO_VECTOR;
            vector_addr <= vic_pkg::RST_ZERO;
        end
        else
        begin
            vec_q <= win;
            vector_addr <= vecbase_q + {24'h000000, win, 2'b00};
        end
    end

    // fast handshake: a fast winner latches the source, the enter code acknowledges it, return or reenable code ends it
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            fs_q <= vic_pkg::VIC_FS_IDLE;
            fs_src_q <= vic_pkg::NO_VECTOR;
            fast_ack_q <= '0;
        end
        else
        begin
            fast_ack_q <= '0;
            case (fs_q)
                vic_pkg::VIC_FS_IDLE:
                    if (any_req && fast_q[win[4:0]])
                    begin
                        fs_q <= vic_pkg::VIC_FS_WAIT;
                        fs_src_q <= win;
                    end
                vic_pkg::VIC_FS_WAIT:
                    if (processor_ack == vic_pkg::VIC_ACK_ENTER)
                    begin
                        fs_q <= vic_pkg::VIC_FS_SERVE;
                        fast_ack_q[fs_src_q[4:0]] <= 1'b1;
                    end
                vic_pkg::VIC_FS_SERVE:
                    if (processor_ack == vic_pkg::VIC_ACK_RETURN || processor_ack == vic_pkg::VIC_ACK_REENABLE)
                        fs_q <= vic_pkg::VIC_FS_IDLE;
                default: fs_q <= vic_pkg::VIC_FS_IDLE;
            endcase
        end
    end

    // request output: level follows armed set gated by both global enable bits, pulse fires once per new request
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            irq <= 1'b0;
            req_prev_q <= 1'b0;
        end
        else
        begin
            req_prev_q <= any_req;
            if (outmode_q)
                irq <= any_req;
            else
                irq <= any_req && !req_prev_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_LEVEL_FOLLOWS: assert property (@(posedge clock) disable iff (sys_rst)
        outmode_q && $stable(outmode_q) |-> irq == $past(any_req)) else $error("level irq mismatch");
    AST_PULSE_ONE: assert property (@(posedge clock) disable iff (sys_rst)
        !outmode_q && $past(!outmode_q) && irq |=> !irq) else $error("pulse longer than one cycle");
    AST_NO_REQ_DISABLED: assert property (@(posedge clock) disable iff (sys_rst)
        !global_q[0] |=> !irq) else $error("irq while globally disabled");
    AST_VEC_WIN: assert property (@(posedge clock) disable iff (sys_rst)
        armed[0] |=> vec_q == 6'h00) else $error("source zero lost priority");
    AST_HOLD_PEND: assert property (@(posedge clock) disable iff (sys_rst)
        pend[0] && !clr[0] |=> pend[0]) else $error("pending dropped without ack");
    AST_CAPTURE_DISABLED: assert property (@(posedge clock) disable iff (sys_rst)
        !sense_q[0] && polarity_q[0] && src_clean_q[0] && !enable_q[0] && NSW < NSRC |=> pend[0])
        else $error("disabled source not captured");
    AST_FAST_ACK: assert property (@(posedge clock) disable iff (sys_rst)
        fs_q == vic_pkg::VIC_FS_WAIT && processor_ack != vic_pkg::VIC_ACK_ENTER |=> fast_ack_q == '0)
        else $error("fast ack without processor acknowledge");
    AST_LEVEL_MASK: assert property (@(posedge clock) disable iff (sys_rst)
        level_q == 6'h00 |-> armed == '0) else $error("masked source armed");
    AST_RD_LATE: assert property (@(posedge clock) disable iff (sys_rst)
        reg_rd && reg_addr == vic_pkg::OFF_ENABLE |=> reg_rdata == 32'($past(enable_q)))
        else $error("enable readback wrong");
endmodule

// ### sim/vic_cpu_model.sv
// vic_cpu_model: processor side that answers the request on the ack code port.
// assumes the request runs in level mode and shares the bench clock.
module vic_cpu_model
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic irq,
    input wire logic en,
    input wire logic [3:0] dly,
    output logic [1:0] processor_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    ////////////////////////////////////////////////////////////////////////////
    // dly gives a prompt or a slow processor; the code returns to none after use
    always_ff @(posedge clock)
    begin
        if (sys_rst || !en)
        begin
            cnt_q <= 4'h0;
            processor_ack <= vic_pkg::VIC_ACK_NONE;
        end
        else if (processor_ack == vic_pkg::VIC_ACK_ENTER)
            processor_ack <= vic_pkg::VIC_ACK_RETURN;
        else if (processor_ack == vic_pkg::VIC_ACK_RETURN)
            processor_ack <= vic_pkg::VIC_ACK_NONE;
        else if (irq && cnt_q == dly)
        begin
            processor_ack <= vic_pkg::VIC_ACK_ENTER;
            cnt_q <= 4'h0;
        end
        else if (irq)
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

// ### sim/tb_vic_top.sv
// tb_vic_top: directed scenarios for the request concentrator.
// assumes vic_top with two software slots and a processor model on the ack port.
module tb_vic_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, sys_rst, reg_wr, reg_rd, cascade_in, cpu_en, irq;
    logic [31:0] src_in, reg_wdata, reg_rdata, vector_addr;
    logic [7:0] reg_addr;
    logic [1:0] processor_ack;
    logic [3:0] cpu_dly;
    int miscompares, n_tests;
    vic_top #(.NSW(2)) vic_top_i (.clock(clock), .sys_rst(sys_rst), .src_in(src_in),
        .cascade_in(cascade_in), .processor_ack(processor_ack), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .vector_addr(vector_addr));
    vic_cpu_model vic_cpu_model_i (.clock(clock), .sys_rst(sys_rst), .irq(irq), .en(cpu_en),
        .dly(cpu_dly), .processor_ack(processor_ack));
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("TB: %0d compares, %0d mismatches", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic wait_irq(input logic v);
        int i;
        // sample after the edge so the new irq has settled
        for (i = 0; i < 50 && irq !== v; i++)
        begin
            @(posedge clock);
            #1;
        end
        #1;
        chk({31'h0, irq}, {31'h0, v});
        if (i == 50)
            stop_test();
    endtask
    // sources pass a synchroniser, so each level is held well past its latency
    task automatic pulse(input logic [31:0] m);
        @(posedge clock);
        src_in <= src_in | m;
        repeat (6) @(posedge clock);
        src_in <= src_in & ~m;
        repeat (8) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({31'h0, irq}, 32'h0);
        rdchk(vic_pkg::OFF_ENABLE, 32'h0);
        rdchk(vic_pkg::OFF_LEVEL, 32'h20);
        rdchk(vic_pkg::OFF_POLARITY, 32'hffff_ffff);
        rdchk(8'h30, 32'h0);
        wr(vic_pkg::OFF_VECBASE, 32'h100);
        rdchk(vic_pkg::OFF_VECBASE, 32'h100);
        $display("TB: reset test done");
    endtask
    task automatic t_level();
        wr(vic_pkg::OFF_OUTMODE, 32'h1);
        pulse(32'h28);
        rdchk(vic_pkg::OFF_STATUS, 32'h28);
        rdchk(vic_pkg::OFF_PENDING, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(vic_pkg::OFF_ENABLE, 32'h28);
        wr(vic_pkg::OFF_GLOBAL, 32'h3);
        wait_irq(1'b1);
        rdchk(vic_pkg::OFF_PENDING, 32'h28);
        chk(vector_addr, 32'h10c);
        wr(vic_pkg::OFF_ACK, 32'h8);
        repeat (3) @(posedge clock);
        chk(vector_addr, 32'h114);
        chk({31'h0, irq}, 32'h1);
        wr(vic_pkg::OFF_ACK, 32'h20);
        wait_irq(1'b0);
        $display("TB: level test done");
    endtask
    task automatic t_edge();
        wr(vic_pkg::OFF_SENSE, 32'h180);
        wr(vic_pkg::OFF_POLARITY, 32'hffff_feff);
        wr(vic_pkg::OFF_ENABLE, 32'h180);
        src_in <= src_in | 32'h100;
        pulse(32'h80);
        pulse(32'h80);
        rdchk(vic_pkg::OFF_STATUS, 32'h80);
        wr(vic_pkg::OFF_ACK, 32'h80);
        rdchk(vic_pkg::OFF_STATUS, 32'h0);
        @(posedge clock);
        src_in <= src_in & ~32'h100;
        repeat (8) @(posedge clock);
        rdchk(vic_pkg::OFF_STATUS, 32'h100);
        wr(vic_pkg::OFF_ACK, 32'h100);
        wait_irq(1'b0);
        $display("TB: edge test done");
    endtask
    task automatic t_pulse();
        int hi;
        hi = 0;
        wr(vic_pkg::OFF_OUTMODE, 32'h0);
        wr(vic_pkg::OFF_ENABLE, 32'h2);
        src_in <= src_in | 32'h2;
        repeat (20)
        begin
            @(posedge clock);
            #1;
            hi += irq;
        end
        chk(hi, 32'h1);
        src_in <= src_in & ~32'h2;
        repeat (8) @(posedge clock);
        wr(vic_pkg::OFF_ACK, 32'h2);
        wr(vic_pkg::OFF_OUTMODE, 32'h1);
        $display("TB: pulse test done");
    endtask
    task automatic t_fast();
        wr(vic_pkg::OFF_FAST, 32'h200);
        wr(vic_pkg::OFF_ENABLE, 32'h200);
        pulse(32'h200);
        wait_irq(1'b1);
        wr(vic_pkg::OFF_ACK, 32'h200);
        rdchk(vic_pkg::OFF_STATUS, 32'h200);
        @(posedge clock);
        cpu_dly <= 4'h3;
        cpu_en <= 1'b1;
        wait_irq(1'b0);
        rdchk(vic_pkg::OFF_STATUS, 32'h0);
        @(posedge clock);
        cpu_en <= 1'b0;
        $display("TB: fast test done");
    endtask
    task automatic t_soft_nest();
        wr(vic_pkg::OFF_STATUS, 32'h4000_0000);
        rdchk(vic_pkg::OFF_STATUS, 32'h4000_0000);
        wr(vic_pkg::OFF_ACK, 32'h4000_0000);
        rdchk(vic_pkg::OFF_STATUS, 32'h0);
        wr(vic_pkg::OFF_ENABLE, 32'h20);
        wr(vic_pkg::OFF_LEVEL, 32'h5);
        pulse(32'h20);
        chk({31'h0, irq}, 32'h0);
        wr(vic_pkg::OFF_LEVEL, 32'h6);
        wait_irq(1'b1);
        wr(vic_pkg::OFF_GLOBAL, 32'h0);
        wait_irq(1'b0);
        wr(vic_pkg::OFF_ACK, 32'h20);
        $display("TB: software and nesting test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        {sys_rst, reg_wr, reg_rd, cascade_in, cpu_en} = 5'h10;
        {src_in, reg_wdata, reg_addr, cpu_dly} = '0;
        miscompares = 0;
        n_tests = 0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_level();
        t_edge();
        t_pulse();
        t_fast();
        t_soft_nest();
        stop_test();
    end
endmodule
